//--- rtl/bus_cycle.v
// Purpose: one read or write cycle on the flash pins
// Assumes: strobes are active low, counts in whole clocks
// Notes:   output enable drops at least two cycles before data drive to avoid contention
`include "flash_host_consts.vh"
module bus_cycle
(
   input  wire                 clock,
   input  wire                 sys_rst,
   input  wire                 start,
   input  wire                 write,
   input  wire [`ADDR_W-1:0]   addr,
   input  wire [`DATA_W-1:0]   wdata,
   input  wire [`DATA_W-1:0]   data_in_sync,
   output reg                  done_q,
   output reg  [`DATA_W-1:0]   rdata_q,
   output reg  [`ADDR_W-1:0]   addr_q,
   output reg  [`DATA_W-1:0]   data_out_q,
   output reg                  data_oe_q,
   output reg                  chip_sel_n_q,
   output reg                  write_n_q,
   output reg                  out_en_n_q
);
   localparam S_IDLE = 2'h0;
   localparam S_SETUP = 2'h1;
   localparam S_PULSE = 2'h2;
   localparam S_END = 2'h3;
   localparam [31:0] WR_CNT = `WR_PULSE_CYC;
   // Two extra clocks cover the data input synchroniser
   localparam [31:0] RD_CNT = `RD_ACCESS_CYC + 2;
   reg [1:0] state_q;
   reg [3:0] cnt_q;
   reg       wr_q;
   always @(posedge clock)
   begin
      done_q <= 1'b0;
      if (sys_rst)
      begin
         state_q      <= S_IDLE;
         cnt_q        <= 4'h0;
         wr_q         <= 1'b0;
         rdata_q      <= 8'h00;
         addr_q       <= 17'h00000;
         data_out_q   <= 8'h00;
         data_oe_q    <= 1'b0;
         chip_sel_n_q <= 1'b1;
         write_n_q    <= 1'b1;
         out_en_n_q   <= 1'b1;
      end
      else
      begin
         case (state_q)
            S_IDLE:
               if (start)
               begin
                  addr_q       <= addr;
                  wr_q         <= write;
                  data_out_q   <= wdata;
                  data_oe_q    <= write;
                  chip_sel_n_q <= 1'b0;
                  state_q      <= S_SETUP;
               end
            S_SETUP:
            begin
               write_n_q  <= ~wr_q;
               out_en_n_q <= wr_q;
               cnt_q      <= wr_q ? WR_CNT[3:0] : RD_CNT[3:0];
               state_q    <= S_PULSE;
            end
            S_PULSE:
               if (cnt_q <= 4'h1)
               begin
                  rdata_q    <= data_in_sync;
                  write_n_q  <= 1'b1;
                  out_en_n_q <= 1'b1;
                  state_q    <= S_END;
               end
               else
                  cnt_q <= cnt_q - 4'h1;
            S_END:
            begin
               // Hold data one cycle past the write strobe rise
               data_oe_q    <= 1'b0;
               chip_sel_n_q <= 1'b1;
               done_q       <= 1'b1;
               state_q      <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule

//--- rtl/flash_host.v
// Purpose: host controller issuing command sequences to a boot-sector flash
// Assumes: flash data returns through two synchroniser flops
// Notes:   completion is detected by toggle-bit polling; no timeout
`include "flash_host_consts.vh"
// How it works
// - Every command is sent as ordinary write cycles on the pins.
// - Byte program uses two writes in bypass mode, four otherwise.
// - Host polls toggle_status_bit until two reads agree.
// - Host drives separate active-low strobes without data contention.
module flash_host
#(
   parameter [16:0] UNLOCK_ADDR1 = 17'h00555,
   parameter [16:0] UNLOCK_ADDR2 = 17'h002AA,
   parameter [7:0]  UNLOCK_DATA1 = 8'hAA,
   parameter [7:0]  UNLOCK_DATA2 = 8'h55,
   parameter [7:0]  CMD_PROGRAM  = 8'hA0,
   parameter [7:0]  CMD_ERASE    = 8'h80,
   parameter [7:0]  CMD_CHIP     = 8'h10,
   parameter [7:0]  CMD_SECTOR   = 8'h30,
   parameter [7:0]  CMD_SUSPEND  = 8'hB0,
   parameter [7:0]  CMD_RESUME   = 8'h30,
   parameter [7:0]  CMD_BYPASS   = 8'h20,
   parameter [7:0]  CMD_BYP_EXIT = 8'h90,
   parameter [7:0]  CMD_RESET    = 8'h00
)
(
   input  wire                 clock,
   input  wire                 sys_rst,
   input  wire                 req,
   input  wire [2:0]           op,
   input  wire [`ADDR_W-1:0]   req_addr,
   input  wire [`DATA_W-1:0]   req_data,
   input  wire                 hw_reset_req,
   output reg                  busy_q,
   output reg                  done_q,
   output reg  [`DATA_W-1:0]   rd_data_q,
   output reg                  bypass_q,
   output wire [`ADDR_W-1:0]   flash_addr,
   input  wire [`DATA_W-1:0]   data_lines_in,
   output wire [`DATA_W-1:0]   data_lines_out,
   output wire                 data_lines_oe,
   output wire                 chip_sel_n,
   output wire                 write_n,
   output wire                 out_en_n,
   output reg                  flash_reset_n_q
);
   localparam S_IDLE = 3'h0;
   localparam S_CMD = 3'h1;
   localparam S_WAIT = 3'h2;
   localparam S_POLL = 3'h3;
   localparam S_RST = 3'h4;
   localparam S_FIN = 3'h5;
   localparam [31:0] RST_CNT = `RST_PULSE_CYC;
   reg  [2:0]          state_q;
   reg  [2:0]          op_q;
   reg  [`ADDR_W-1:0]  addr_q;
   reg  [`DATA_W-1:0]  data_q;
   reg  [2:0]          step_q;
   reg  [2:0]          nsteps_q;
   reg                 polling_q;
   reg                 have_prev_q;
   reg                 prev_tog_q;
   reg  [4:0]          rst_cnt_q;
   reg  [`DATA_W-1:0]  sync1_q;
   reg  [`DATA_W-1:0]  sync2_q;
   reg                 cyc_start_q;
   reg                 cyc_write_q;
   reg  [`ADDR_W-1:0]  cyc_addr_q;
   reg  [`DATA_W-1:0]  cyc_data_q;
   wire                cyc_done;
   wire [`DATA_W-1:0]  cyc_rdata;
   // Write sequence lookup: index = step within a command, plus two for bypass program
   function [24:0] seq_word;
      input [2:0]         o;
      input [2:0]         s;
      input               byp;
      input [`ADDR_W-1:0] a;
      input [`DATA_W-1:0] d;
      reg   [2:0]         k;
      begin
         k = s;
         if (o == `OP_PROGRAM && byp)
            k = s + 3'h2;
         case (k)
            3'h0:    seq_word = {UNLOCK_ADDR1, UNLOCK_DATA1};
            3'h1:    seq_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
            3'h2:    seq_word = {UNLOCK_ADDR1, (o == `OP_PROGRAM) ? CMD_PROGRAM :
                                 (o == `OP_BYPASS_ON) ? CMD_BYPASS : CMD_ERASE};
            3'h3:    seq_word = (o == `OP_PROGRAM) ? {a, d} : {UNLOCK_ADDR1, UNLOCK_DATA1};
            3'h4:    seq_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
            default: seq_word = (o == `OP_CHIP_ERASE) ? {UNLOCK_ADDR1, CMD_CHIP} :
                                {a, CMD_SECTOR};
         endcase
      end
   endfunction
   // Single-write commands bypass the unlock pair
   function [24:0] single_word;
      input [2:0]         o;
      input [`ADDR_W-1:0] a;
      begin
         case (o)
            `OP_SUSPEND:    single_word = {a, CMD_SUSPEND};
            `OP_RESUME:     single_word = {a, CMD_RESUME};
            `OP_BYPASS_OFF: single_word = {a, CMD_BYP_EXIT};
            default:        single_word = {a, CMD_RESET};
         endcase
      end
   endfunction
   function [2:0] step_count;
      input [2:0] o;
      input       byp;
      begin
         case (o)
            `OP_PROGRAM:    step_count = byp ? 3'h2 : 3'h4;
            `OP_CHIP_ERASE: step_count = 3'h6;
            `OP_SECT_ERASE: step_count = 3'h6;
            `OP_BYPASS_ON:  step_count = 3'h3;
            `OP_BYPASS_OFF: step_count = 3'h2;
            default:        step_count = 3'h1;
         endcase
      end
   endfunction
   wire [24:0] word_now = (op_q == `OP_SUSPEND || op_q == `OP_RESUME) ?
                          single_word(op_q, addr_q) :
                          (op_q == `OP_BYPASS_OFF) ?
                          (step_q == 3'h0 ? {addr_q, CMD_BYP_EXIT} : {addr_q, CMD_RESET}) :
                          seq_word(op_q, step_q, bypass_q, addr_q, data_q);
   bus_cycle u_cycle
   (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .start        (cyc_start_q),
      .write        (cyc_write_q),
      .addr         (cyc_addr_q),
      .wdata        (cyc_data_q),
      .data_in_sync (sync2_q),
      .done_q       (cyc_done),
      .rdata_q      (cyc_rdata),
      .addr_q       (flash_addr),
      .data_out_q   (data_lines_out),
      .data_oe_q    (data_lines_oe),
      .chip_sel_n_q (chip_sel_n),
      .write_n_q    (write_n),
      .out_en_n_q   (out_en_n)
   );
   always @(posedge clock)
   begin
      sync1_q <= data_lines_in;
      sync2_q <= sync1_q;
      cyc_start_q <= 1'b0;
      done_q <= 1'b0;
      if (sys_rst)
      begin
         state_q         <= S_IDLE;
         op_q            <= `OP_READ;
         addr_q          <= 17'h00000;
         data_q          <= 8'h00;
         step_q          <= 3'h0;
         nsteps_q        <= 3'h0;
         polling_q       <= 1'b0;
         have_prev_q     <= 1'b0;
         prev_tog_q      <= 1'b0;
         rst_cnt_q       <= 5'h00;
         cyc_write_q     <= 1'b0;
         cyc_addr_q      <= 17'h00000;
         cyc_data_q      <= 8'h00;
         busy_q          <= 1'b0;
         rd_data_q       <= `ERASED_BYTE;
         bypass_q        <= 1'b0;
         flash_reset_n_q <= 1'b1;
      end
      else
      begin
         case (state_q)
            S_IDLE:
               if (hw_reset_req)
               begin
                  flash_reset_n_q <= 1'b0;
                  rst_cnt_q       <= RST_CNT[4:0];
                  busy_q          <= 1'b1;
                  state_q         <= S_RST;
               end
               else if (req)
               begin
                  op_q     <= op;
                  addr_q   <= req_addr;
                  data_q   <= req_data;
                  step_q   <= 3'h0;
                  nsteps_q <= step_count(op, bypass_q);
                  busy_q   <= 1'b1;
                  state_q  <= S_CMD;
               end
            S_CMD:
            begin
               cyc_start_q <= 1'b1;
               if (op_q == `OP_READ)
               begin
                  cyc_write_q <= 1'b0;
                  cyc_addr_q  <= addr_q;
               end
               else
               begin
                  cyc_write_q <= 1'b1;
                  cyc_addr_q  <= word_now[24:8];
                  cyc_data_q  <= word_now[7:0];
               end
               state_q <= S_WAIT;
            end
            S_WAIT:
               if (cyc_done)
               begin
                  if (polling_q)
                  begin
                     // Toggle stops when the internal algorithm ends
                     if (have_prev_q && prev_tog_q == cyc_rdata[`TOGGLE_BIT])
                     begin
                        polling_q <= 1'b0;
                        rd_data_q <= cyc_rdata;
                        state_q   <= S_FIN;
                     end
                     else
                     begin
                        have_prev_q <= 1'b1;
                        prev_tog_q  <= cyc_rdata[`TOGGLE_BIT];
                        state_q     <= S_POLL;
                     end
                  end
                  else if (op_q == `OP_READ)
                  begin
                     rd_data_q <= cyc_rdata;
                     state_q   <= S_FIN;
                  end
                  else if (step_q + 3'h1 < nsteps_q)
                  begin
                     step_q  <= step_q + 3'h1;
                     state_q <= S_CMD;
                  end
                  else if (op_q == `OP_PROGRAM || op_q == `OP_CHIP_ERASE ||
                           op_q == `OP_SECT_ERASE)
                  begin
                     polling_q   <= 1'b1;
                     have_prev_q <= 1'b0;
                     state_q     <= S_POLL;
                  end
                  else
                  begin
                     if (op_q == `OP_BYPASS_ON)
                        bypass_q <= 1'b1;
                     if (op_q == `OP_BYPASS_OFF)
                        bypass_q <= 1'b0;
                     state_q <= S_FIN;
                  end
               end
            S_POLL:
            begin
               cyc_start_q <= 1'b1;
               cyc_write_q <= 1'b0;
               cyc_addr_q  <= addr_q;
               state_q     <= S_WAIT;
            end
            S_RST:
               if (rst_cnt_q <= 5'h01)
               begin
                  flash_reset_n_q <= 1'b1;
                  bypass_q        <= 1'b0;
                  state_q         <= S_FIN;
               end
               else
                  rst_cnt_q <= rst_cnt_q - 5'h01;
            S_FIN:
            begin
               busy_q  <= 1'b0;
               done_q  <= 1'b1;
               state_q <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule

//--- rtl/flash_host_consts.vh
// Purpose: constants for the boot-sector flash host controller
// Assumes: 20 MHz clock, 50 ns period
// Notes:   command cycle addresses and codes are parameters of the top
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
`define ADDR_W          17
`define DATA_W          8
`define CLK_PERIOD_NS   50
`define WR_PULSE_NS     100
`define WR_PULSE_CYC    ((`WR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_ACCESS_NS    100
`define RD_ACCESS_CYC   ((`RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_NS    500
`define RST_PULSE_CYC   ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_BIT        7
`define TOGGLE_BIT      6
`define ERASED_BYTE     8'hFF
`define OP_READ         3'h0
`define OP_PROGRAM      3'h1
`define OP_CHIP_ERASE   3'h2
`define OP_SECT_ERASE   3'h3
`define OP_SUSPEND      3'h4
`define OP_RESUME       3'h5
`define OP_BYPASS_ON    3'h6
`define OP_BYPASS_OFF   3'h7
`endif

//--- verification/boot_sector_flash_command_control_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: 50 ns clock, device model on the far side of the pins
// Notes:   write counts are read from the model to see sequence length
`include "flash_host_consts.vh"
module boot_sector_flash_command_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg                clock = 1'b0;
   reg                sys_rst = 1'b1;
   reg                req = 1'b0;
   reg                hw_reset_req = 1'b0;
   reg                temp_unprotect = 1'b0;
   reg  [2:0]         op = 3'h0;
   reg  [`ADDR_W-1:0] req_addr = 17'h00000;
   reg  [`DATA_W-1:0] req_data = 8'h00;
   wire               busy_q, done_q, bypass_q, data_lines_oe;
   wire               chip_sel_n, write_n, out_en_n, flash_reset_n_q;
   wire [`DATA_W-1:0] rd_data_q, data_lines_out, dev_rdata, data_lines;
   wire [`ADDR_W-1:0] flash_addr;
   integer            n_mismatch = 0;
   integer            samples_checked = 0;
   integer            w;
   always #25 clock = ~clock;
   assign data_lines = data_lines_oe ? data_lines_out : dev_rdata;
   flash_host u_dut
   (
      .clock(clock), .sys_rst(sys_rst), .req(req), .op(op), .req_addr(req_addr),
      .req_data(req_data), .hw_reset_req(hw_reset_req), .busy_q(busy_q),
      .done_q(done_q), .rd_data_q(rd_data_q), .bypass_q(bypass_q),
      .flash_addr(flash_addr), .data_lines_in(data_lines),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
      .flash_reset_n_q(flash_reset_n_q)
   );
   flash_device_model u_flash
   (
      .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
      .reset_n(flash_reset_n_q), .temp_unprotect(temp_unprotect),
      .addr(flash_addr), .wdata(data_lines), .rdata(dev_rdata)
   );
   task check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   task do_op(input [2:0] o, input [16:0] a, input [7:0] d, input hw);
      integer k;
      begin
         @(posedge clock);
         req <= !hw;
         hw_reset_req <= hw;
         op <= o;
         req_addr <= a;
         req_data <= d;
         @(posedge clock);
         req <= 1'b0;
         hw_reset_req <= 1'b0;
         @(negedge clock);
         check(busy_q, 1'b1);
         k = 0;
         while (k < 4000 && done_q !== 1'b1)
         begin
            @(negedge clock);
            k = k + 1;
         end
         check(done_q, 1'b1);
         check(busy_q, 1'b0);
      end
   endtask
   task t_program;
      begin
         do_op(`OP_READ, 17'h1FFFF, 8'h00, 1'b0);
         check(rd_data_q, 8'hFF);
         w = u_flash.n_writes;
         do_op(`OP_PROGRAM, 17'h1BFFF, 8'h5A, 1'b0);
         check(u_flash.n_writes - w, 4);
         check(rd_data_q, 8'h5A);
         do_op(`OP_READ, 17'h1BFFF, 8'h00, 1'b0);
         check(rd_data_q, 8'h5A);
         do_op(`OP_PROGRAM, 17'h1BFFF, 8'hF0, 1'b0);
         check(rd_data_q, 8'h50);
         $display("test program finished");
      end
   endtask
   task t_bypass;
      begin
         w = u_flash.n_writes;
         do_op(`OP_BYPASS_ON, 17'h00000, 8'h00, 1'b0);
         check(u_flash.n_writes - w, 3);
         check(bypass_q, 1'b1);
         w = u_flash.n_writes;
         do_op(`OP_PROGRAM, 17'h08000, 8'h33, 1'b0);
         check(u_flash.n_writes - w, 2);
         check(rd_data_q, 8'h33);
         do_op(`OP_BYPASS_OFF, 17'h00000, 8'h00, 1'b0);
         check({bypass_q, u_flash.bypass}, 2'h0);
         $display("test bypass finished");
      end
   endtask
   task t_erase;
      begin
         do_op(`OP_PROGRAM, 17'h00010, 8'hA5, 1'b0);
         do_op(`OP_PROGRAM, 17'h04010, 8'h3C, 1'b0);
         do_op(`OP_SECT_ERASE, 17'h04000, 8'h00, 1'b0);
         do_op(`OP_READ, 17'h04010, 8'h00, 1'b0);
         check(rd_data_q, 8'hFF);
         do_op(`OP_READ, 17'h00010, 8'h00, 1'b0);
         check(rd_data_q, 8'hA5);
         $display("test sector erase finished");
      end
   endtask
   task t_protect;
      begin
         do_op(`OP_PROGRAM, 17'h1F000, 8'h00, 1'b0);
         do_op(`OP_READ, 17'h1F000, 8'h00, 1'b0);
         check(rd_data_q, 8'hFF);
         temp_unprotect <= 1'b1;
         do_op(`OP_PROGRAM, 17'h1F000, 8'h12, 1'b0);
         do_op(`OP_READ, 17'h1F000, 8'h00, 1'b0);
         check(rd_data_q, 8'h12);
         temp_unprotect <= 1'b0;
         do_op(`OP_CHIP_ERASE, 17'h00000, 8'h00, 1'b0);
         do_op(`OP_READ, 17'h00010, 8'h00, 1'b0);
         check(rd_data_q, 8'hFF);
         do_op(`OP_READ, 17'h1F000, 8'h00, 1'b0);
         check(rd_data_q, 8'h12);
         $display("test protect and chip erase finished");
      end
   endtask
   task t_suspend;
      begin
         w = u_flash.n_writes;
         do_op(`OP_SUSPEND, 17'h04000, 8'h00, 1'b0);
         check(u_flash.n_writes - w, 1);
         check(u_flash.last_wdata, 8'hB0);
         do_op(`OP_RESUME, 17'h04000, 8'h00, 1'b0);
         check(u_flash.last_wdata, 8'h30);
         $display("test suspend finished");
      end
   endtask
   task t_reset;
      begin
         do_op(`OP_BYPASS_ON, 17'h00000, 8'h00, 1'b0);
         do_op(`OP_READ, 17'h00000, 8'h00, 1'b1);
         check({bypass_q, u_flash.bypass}, 2'h0);
         w = u_flash.n_writes;
         do_op(`OP_PROGRAM, 17'h00020, 8'h77, 1'b0);
         check(u_flash.n_writes - w, 4);
         check(rd_data_q, 8'h77);
         $display("test hardware reset finished");
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial
   begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      t_program;
      t_bypass;
      t_erase;
      t_protect;
      t_suspend;
      t_reset;
      wrap_up;
   end
   // Roughly forty times the expected run length
   initial
   begin
      #2000000;
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
endmodule
bind flash_host flash_host_assertions u_chk
(
   .clock(clock), .sys_rst(sys_rst), .busy_q(busy_q), .done_q(done_q),
   .flash_addr(flash_addr), .data_lines_out(data_lines_out),
   .data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n), .write_n(write_n),
   .out_en_n(out_en_n), .flash_reset_n_q(flash_reset_n_q)
);

//--- verification/flash_device_model.sv
// Purpose: behavioural boot-sector flash answering the host pins
// Assumes: top boot variant, unlock addresses 555 and 2AA
// Notes:   busy lasts a fixed count of status reads, not real time
`include "flash_host_consts.vh"
module flash_device_model
#(
   parameter [9:0]   PROTECTED   = 10'h200,
   parameter integer PROG_READS  = 3,
   parameter integer ERASE_READS = 6
)
(
   input  wire                chip_sel_n,
   input  wire                write_n,
   input  wire                out_en_n,
   input  wire                reset_n,
   input  wire                temp_unprotect,
   input  wire [`ADDR_W-1:0]  addr,
   input  wire [`DATA_W-1:0]  wdata,
   output wire [`DATA_W-1:0]  rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [7:0] mem [0:131071];
   reg [7:0] drv_q;
   reg [7:0] last_wdata;
   reg [1:0] unl_q;
   reg       armed_q, prog_q, exit_q, bypass, susp_q, tog_q;
   integer   busy_reads, n_writes, i;
   function automatic integer sect(input [16:0] a);
      sect = (a < 17'h1C000) ? a[16:14] : (a < 17'h1E000) ? 7 : (a < 17'h1F000) ? 8 : 9;
   endfunction
   function automatic ok(input [16:0] a);
      ok = temp_unprotect || !PROTECTED[sect(a)];
   endfunction
   task automatic erase(input sector_only);
      integer j;
      begin
         for (j = 0; j < 131072; j = j + 1)
            if ((!sector_only || sect(j) == sect(addr)) && ok(j))
               mem[j] = `ERASED_BYTE;
         busy_reads = ERASE_READS;
      end
   endtask
   initial
   begin
      for (i = 0; i < 131072; i = i + 1)
         mem[i] = `ERASED_BYTE;
      {unl_q, armed_q, prog_q, exit_q, bypass, susp_q, tog_q} = 0;
      drv_q = 8'h00;
      last_wdata = 8'h00;
      busy_reads = 0;
      n_writes = 0;
   end
   // Released lines show the inverse, so a stale byte never passes
   assign rdata = (!chip_sel_n && !out_en_n && reset_n) ? drv_q : ~drv_q;
   always @(negedge reset_n)
   begin
      {unl_q, armed_q, prog_q, exit_q, bypass, susp_q} = 0;
      busy_reads = 0;
   end
   always @(negedge out_en_n)
   begin
      #1;
      if (busy_reads > 0 && !susp_q)
      begin
         tog_q = ~tog_q;
         busy_reads = busy_reads - 1;
         drv_q = {~mem[addr][7], tog_q, 6'h00};
      end
      else
         drv_q = mem[addr];
   end
   always @(posedge write_n)
   begin
      if (!chip_sel_n && reset_n)
      begin
         n_writes = n_writes + 1;
         last_wdata = wdata;
         if (busy_reads > 0 || susp_q)
            susp_q = (wdata == 8'hB0) ? 1'b1 : (wdata == 8'h30) ? 1'b0 : susp_q;
         else if (prog_q)
         begin
            prog_q = 1'b0;
            if (ok(addr))
            begin
               mem[addr] = mem[addr] & wdata;
               busy_reads = PROG_READS;
            end
         end
         else if (exit_q)
         begin
            bypass = (wdata != 8'h00);
            exit_q = 1'b0;
         end
         else if (bypass)
         begin
            prog_q = (wdata == 8'hA0);
            exit_q = (wdata == 8'h90);
         end
         else if (unl_q == 2'h0)
            unl_q = (addr == 17'h00555 && wdata == 8'hAA) ? 2'h1 : 2'h0;
         else if (unl_q == 2'h1)
            unl_q = (addr == 17'h002AA && wdata == 8'h55) ? 2'h2 : 2'h0;
         else
         begin
            unl_q = 2'h0;
            prog_q = (wdata == 8'hA0);
            bypass = (wdata == 8'h20);
            if (armed_q && (wdata == 8'h10 || wdata == 8'h30))
               erase(wdata == 8'h30);
            armed_q = (wdata == 8'h80);
         end
      end
   end
endmodule

//--- verification/flash_host_assertions.sv
// Purpose: pin-level checks on the flash host controller
// Assumes: one clock, synchronous active-high reset
// Notes:   reset pulse width is counted in helper logic
`include "flash_host_consts.vh"
module flash_host_assertions
(
   input wire                clock,
   input wire                sys_rst,
   input wire                busy_q,
   input wire                done_q,
   input wire [`ADDR_W-1:0]  flash_addr,
   input wire [`DATA_W-1:0]  data_lines_out,
   input wire                data_lines_oe,
   input wire                chip_sel_n,
   input wire                write_n,
   input wire                out_en_n,
   input wire                flash_reset_n_q
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [4:0] low_cnt_q;
   always @(posedge clock)
   begin
      if (sys_rst)
         low_cnt_q <= 5'h00;
      else if (!flash_reset_n_q)
         low_cnt_q <= low_cnt_q + 5'h01;
      else
         low_cnt_q <= 5'h00;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   sequence wr_pulse;
      !write_n [*2] ##1 write_n;
   endsequence
   sequence rd_pulse;
      !out_en_n [*4] ##1 out_en_n;
   endsequence
   wr_pulse_len_a: assert property ($fell(write_n) |-> wr_pulse)
      else $error("write strobe width wrong");
   rd_pulse_len_a: assert property ($fell(out_en_n) |-> rd_pulse)
      else $error("read strobe width wrong");
   strobe_select_a: assert property ((!write_n || !out_en_n) |-> !chip_sel_n)
      else $error("strobe without chip select");
   no_contention_a: assert property (data_lines_oe |-> out_en_n)
      else $error("data driven while output enabled");
   wr_data_hold_a: assert property ((!write_n && !$past(write_n))
      |-> data_lines_oe && $stable(data_lines_out) && $stable(flash_addr))
      else $error("write data moved inside strobe");
   reset_width_a: assert property ($rose(flash_reset_n_q)
      |-> low_cnt_q == `RST_PULSE_CYC)
      else $error("reset pulse width wrong");
   done_single_a: assert property (done_q |=> !done_q)
      else $error("done longer than one cycle");
   idle_bus_a: assert property (!busy_q |-> chip_sel_n && write_n && !data_lines_oe)
      else $error("bus active while idle");
endmodule
